// ==== pooc_pkg.sv ====
// Shared constants and types for the power on/off controller.
// Assumes a single 125 MHz clock domain and plain-port control bits.
package pooc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int DEBOUNCE_TIME_US = 30;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int MRST_TIME_MS = 8;
  localparam int MRST_CYCLES = (MRST_TIME_MS * 1000000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int SEQ_TIME_US = 10;
  localparam int SEQ_CYCLES = (SEQ_TIME_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int COUNT_W = 24;

  // ----------------------------------------------------------------
  // Enable input modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PUSH_BUTTON = 2'h0;
  localparam logic [1:0] MODE_SLIDE_SWITCH = 2'h1;
  localparam logic [1:0] MODE_LOGIC = 2'h2;

  // ----------------------------------------------------------------
  // Software control commands
  // ----------------------------------------------------------------
  localparam logic [2:0] SWC_NONE = 3'h0;
  localparam logic [2:0] SWC_COLD_RESET = 3'h1;
  localparam logic [2:0] SWC_POWER_OFF = 3'h2;
  localparam logic [2:0] SWC_ENTER_STANDBY = 3'h3;
  localparam logic [2:0] SWC_LEAVE_STANDBY = 3'h4;

  // ----------------------------------------------------------------
  // Event record flag positions and reset value
  // ----------------------------------------------------------------
  localparam int ERC_UVLO = 0;
  localparam int ERC_OVLO = 1;
  localparam int ERC_THERMAL_OVERLOAD_FLAG = 2;
  localparam int ERC_MRST = 3;
  localparam int ERC_SFT_COLD = 4;
  localparam int ERC_SFT_OFF = 5;
  localparam int ERC_W = 6;
  localparam logic [5:0] ERC_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    POOC_RESET = 3'b000,
    POOC_SHUTDOWN = 3'b001,
    POOC_CHECK = 3'b010,
    POOC_POWER_UP = 3'b011,
    POOC_RESOURCE_ON = 3'b100,
    POOC_POWER_DOWN = 3'b101,
    POOC_STANDBY = 3'b110,
    POOC_BIAS_OFF = 3'b111
  } pooc_state_e;

endpackage : pooc_pkg

// ==== pooc_debounce.sv ====
// Debouncer for the active-low enable input.
// Assumes the input has already been synchronised to clock.
module pooc_debounce #(
  parameter int CYCLES = pooc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic raw_in,
  output logic level_out,
  output logic fall_pulse
);

  typedef struct packed {
    logic level;
    logic fall;
    logic [pooc_pkg::COUNT_W-1:0] count;
  } pooc_deb_s;

  pooc_deb_s st_reg;
  pooc_deb_s st_next;

  // ----------------------------------------------------------------
  // Stability counter
  // ----------------------------------------------------------------
  // The level only follows the input after it stayed put for the whole period.
  always_comb begin
    st_next = st_reg;
    st_next.fall = 1'b0;
    if (raw_in == st_reg.level) begin
      st_next.count = '0;
    end else if (st_reg.count >= pooc_pkg::COUNT_W'(CYCLES - 1)) begin
      st_next.count = '0;
      st_next.level = raw_in;
      st_next.fall = ~raw_in;
    end else begin
      st_next.count = st_reg.count + 1'b1;
    end
  end

  // Idle level is high, as the pin rests pulled up.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{level: 1'b1, fall: 1'b0, count: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.level;
  assign fall_pulse = st_reg.fall;

endmodule : pooc_debounce

// ==== pooc_controller.sv ====
// Top-level on/off state controller of a power-management device.
// Assumes analog comparators and a command decoder on the same supply;
// supply and fault inputs come from outside the clock domain.
//
// Behaviour
// - Interrupt output goes low whenever any unmasked interrupt is pending.
// - While supply is below the reset threshold, stay in reset.
// - Supply above the reset threshold moves reset to Shutdown.
// - Shutdown keeps bias and command port off; event flags are kept.
// - Push-button or slide-switch mode: debounced falling enable edge wakes.
// - Logic mode: low enable level wakes, no edge detection.
// - Internal wake flag from a cold-reset command also wakes.
// - Power-up starts only when undervoltage, overvoltage, thermal flags are zero.
// - Normal path: Shutdown, wake, fault check, power-up, Resource On.
// - Manual reset in Resource On powers down, drops bias, reaches Shutdown.
// - Logic mode code is 0b10, suited to subordinate use.
// - Off command, or enable high in logic mode, powers down to Shutdown.
// - Command 0x3 powers down outputs into Standby, bias kept on.
// - Command 0x4 in Standby wakes and returns to Resource On.
// - Command 0b01 is cold reset, 0b10 power-off; both power down.
// - Standby: sequenced outputs off, forced outputs on, bias on, await wake.
// - Any powered state: thermal, under or overvoltage lockout forces shutdown.
// - Manual reset: push-button held low, slide-switch held high, for set time.
module pooc_controller #(
  parameter int IRQ_W = 8,
  parameter int MRST_CYC = pooc_pkg::MRST_CYCLES,
  parameter int DEB_CYC = pooc_pkg::DEBOUNCE_CYCLES,
  parameter int SEQ_CYC = pooc_pkg::SEQ_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supply_above_por,
  input wire logic supply_uvlo,
  input wire logic supply_ovlo,
  input wire logic thermal_overload_flag,
  input wire logic power_enable_in_low,
  input wire logic [1:0] enable_input_mode,
  input wire logic [2:0] software_control_cmd,
  input wire logic software_control_strobe,
  input wire logic [IRQ_W-1:0] irq_pending,
  input wire logic [IRQ_W-1:0] irq_mask,
  input wire logic erc_clear,
  output logic irq_out_low_o,
  output logic irq_out_low_oe,
  output logic bias_enable,
  output logic cmd_port_enable,
  output logic sequenced_outputs_on,
  output logic forced_outputs_on,
  output logic [pooc_pkg::ERC_W-1:0] event_record_flags,
  output logic [2:0] controller_state
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Analog comparator and pin levels are asynchronous to clock.
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic por_ok;
  logic uvlo_s;
  logic ovlo_s;
  logic thermal_overload_flag_s;
  logic en_low_s;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 5'h10;
      sync2_reg <= 5'h10;
    end else begin
      sync1_reg <= {power_enable_in_low, thermal_overload_flag, supply_ovlo, supply_uvlo, supply_above_por};
      sync2_reg <= sync1_reg;
    end
  end

  assign por_ok = sync2_reg[0];
  assign uvlo_s = sync2_reg[1];
  assign ovlo_s = sync2_reg[2];
  assign thermal_overload_flag_s = sync2_reg[3];
  assign en_low_s = sync2_reg[4];

  // ----------------------------------------------------------------
  // Enable debounce
  // ----------------------------------------------------------------
  logic en_deb;
  logic en_fall;

  pooc_debounce #(
    .CYCLES(DEB_CYC)
  ) u_debounce (
    .clock(clock),
    .rst_b(rst_b),
    .raw_in(en_low_s),
    .level_out(en_deb),
    .fall_pulse(en_fall)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pooc_pkg::pooc_state_e state;
    logic [pooc_pkg::ERC_W-1:0] erc;
    logic wake_flag;
    logic to_standby;
    logic [pooc_pkg::COUNT_W-1:0] mrst_count;
    logic [pooc_pkg::COUNT_W-1:0] seq_count;
    logic irq_low;
  } pooc_ctl_s;

  pooc_ctl_s st_reg;
  pooc_ctl_s st_next;

  logic logic_mode;
  logic mrst_level;
  logic mrst_hit;
  logic lockout;
  logic wake;
  logic cmd_cold;
  logic cmd_off;
  logic cmd_stby;
  logic cmd_exit;
  logic seq_done;

  assign logic_mode = (enable_input_mode == pooc_pkg::MODE_LOGIC);
  // Level that counts toward a manual reset depends on the switch style.
  assign mrst_level = (enable_input_mode == pooc_pkg::MODE_SLIDE_SWITCH) ? en_deb : ~en_deb;
  assign mrst_hit = !logic_mode && mrst_level && (st_reg.mrst_count >= pooc_pkg::COUNT_W'(MRST_CYC - 1));
  assign lockout = thermal_overload_flag_s || uvlo_s || ovlo_s;
  assign cmd_cold = software_control_strobe && (software_control_cmd == pooc_pkg::SWC_COLD_RESET);
  assign cmd_off = software_control_strobe && (software_control_cmd == pooc_pkg::SWC_POWER_OFF);
  assign cmd_stby = software_control_strobe && (software_control_cmd == pooc_pkg::SWC_ENTER_STANDBY);
  assign cmd_exit = software_control_strobe && (software_control_cmd == pooc_pkg::SWC_LEAVE_STANDBY);
  // Wake sources out of Shutdown: edge, level or remembered cold reset.
  assign wake = (logic_mode ? ~en_low_s : en_fall) || st_reg.wake_flag;
  assign seq_done = (st_reg.seq_count >= pooc_pkg::COUNT_W'(SEQ_CYC - 1));

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Sequencer slots are modelled as one fixed delay; the real slot timing lives elsewhere.
  always_comb begin
    st_next = st_reg;
    st_next.seq_count = '0;
    st_next.irq_low = |(irq_pending & ~irq_mask);
    if (erc_clear) begin
      st_next.erc = pooc_pkg::ERC_RESET;
    end
    // Manual-reset hold time, counted only while powered on.
    if (st_reg.state == pooc_pkg::POOC_RESOURCE_ON && mrst_level && !mrst_hit) begin
      st_next.mrst_count = st_reg.mrst_count + 1'b1;
    end else if (!mrst_level || st_reg.state != pooc_pkg::POOC_RESOURCE_ON) begin
      st_next.mrst_count = '0;
    end
    case (st_reg.state)
      pooc_pkg::POOC_RESET: begin
        if (por_ok) begin
          st_next.state = pooc_pkg::POOC_SHUTDOWN;
        end
      end
      pooc_pkg::POOC_SHUTDOWN: begin
        if (wake) begin
          st_next.state = pooc_pkg::POOC_CHECK;
          st_next.wake_flag = 1'b0;
          // Comparators are live again, so the record reflects this check.
          st_next.erc[pooc_pkg::ERC_UVLO] = uvlo_s;
          st_next.erc[pooc_pkg::ERC_OVLO] = ovlo_s;
          st_next.erc[pooc_pkg::ERC_THERMAL_OVERLOAD_FLAG] = thermal_overload_flag_s;
        end
      end
      pooc_pkg::POOC_CHECK: begin
        if (st_reg.erc[pooc_pkg::ERC_UVLO] || st_reg.erc[pooc_pkg::ERC_OVLO] || st_reg.erc[pooc_pkg::ERC_THERMAL_OVERLOAD_FLAG]) begin
          st_next.state = pooc_pkg::POOC_BIAS_OFF;
        end else begin
          st_next.state = pooc_pkg::POOC_POWER_UP;
        end
      end
      pooc_pkg::POOC_POWER_UP, pooc_pkg::POOC_POWER_DOWN: begin
        st_next.seq_count = st_reg.seq_count + 1'b1;
        if (seq_done) begin
          st_next.seq_count = '0;
          if (st_reg.state == pooc_pkg::POOC_POWER_UP) begin
            st_next.state = pooc_pkg::POOC_RESOURCE_ON;
          end else if (st_reg.to_standby) begin
            st_next.state = pooc_pkg::POOC_STANDBY;
          end else begin
            st_next.state = pooc_pkg::POOC_BIAS_OFF;
          end
        end
      end
      pooc_pkg::POOC_RESOURCE_ON: begin
        st_next.to_standby = 1'b0;
        if (mrst_hit) begin
          st_next.state = pooc_pkg::POOC_POWER_DOWN;
          st_next.erc[pooc_pkg::ERC_MRST] = 1'b1;
        end else if (logic_mode && en_low_s) begin
          st_next.state = pooc_pkg::POOC_POWER_DOWN;
          st_next.erc[pooc_pkg::ERC_MRST] = 1'b1;
        end else if (cmd_cold) begin
          st_next.state = pooc_pkg::POOC_POWER_DOWN;
          st_next.wake_flag = 1'b1;
          st_next.erc[pooc_pkg::ERC_SFT_COLD] = 1'b1;
        end else if (cmd_off) begin
          st_next.state = pooc_pkg::POOC_POWER_DOWN;
          st_next.erc[pooc_pkg::ERC_SFT_OFF] = 1'b1;
        end else if (cmd_stby) begin
          st_next.state = pooc_pkg::POOC_POWER_DOWN;
          st_next.to_standby = 1'b1;
        end
      end
      pooc_pkg::POOC_STANDBY: begin
        if (cmd_exit || (!logic_mode && en_fall)) begin
          st_next.state = pooc_pkg::POOC_CHECK;
          st_next.to_standby = 1'b0;
        end
      end
      pooc_pkg::POOC_BIAS_OFF: begin
        st_next.state = pooc_pkg::POOC_SHUTDOWN;
      end
      default: begin
        st_next.state = pooc_pkg::POOC_RESET;
      end
    endcase
    // Lockout while powered skips the sequence and drops bias after one Bias-off cycle.
    if (lockout && (st_reg.state == pooc_pkg::POOC_POWER_UP || st_reg.state == pooc_pkg::POOC_RESOURCE_ON ||
                    st_reg.state == pooc_pkg::POOC_POWER_DOWN || st_reg.state == pooc_pkg::POOC_STANDBY)) begin
      st_next.state = pooc_pkg::POOC_BIAS_OFF;
      st_next.to_standby = 1'b0;
      st_next.erc[pooc_pkg::ERC_UVLO] = st_reg.erc[pooc_pkg::ERC_UVLO] | uvlo_s;
      st_next.erc[pooc_pkg::ERC_OVLO] = st_reg.erc[pooc_pkg::ERC_OVLO] | ovlo_s;
      st_next.erc[pooc_pkg::ERC_THERMAL_OVERLOAD_FLAG] = st_reg.erc[pooc_pkg::ERC_THERMAL_OVERLOAD_FLAG] | thermal_overload_flag_s;
    end
    // Supply collapse overrides everything; the event record is kept.
    if (!por_ok) begin
      st_next.state = pooc_pkg::POOC_RESET;
      st_next.wake_flag = 1'b0;
      st_next.to_standby = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '{state: pooc_pkg::POOC_RESET, erc: pooc_pkg::ERC_RESET, wake_flag: 1'b0,
                  to_standby: 1'b0, mrst_count: '0, seq_count: '0, irq_low: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever drives low, released otherwise.
  assign irq_out_low_o = 1'b0;
  assign irq_out_low_oe = st_reg.irq_low;
  assign bias_enable = (st_reg.state != pooc_pkg::POOC_RESET) && (st_reg.state != pooc_pkg::POOC_SHUTDOWN);
  assign cmd_port_enable = bias_enable;
  assign sequenced_outputs_on = (st_reg.state == pooc_pkg::POOC_RESOURCE_ON);
  assign forced_outputs_on = (st_reg.state == pooc_pkg::POOC_RESOURCE_ON) ||
                             (st_reg.state == pooc_pkg::POOC_STANDBY);
  assign event_record_flags = st_reg.erc;
  assign controller_state = st_reg.state;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_powering_down;
    st_reg.state == pooc_pkg::POOC_POWER_DOWN;
  endsequence

  // Last power-down cycle of a standby request with nothing overriding it.
  sequence s_standby_due;
    st_reg.to_standby && seq_done && !lockout && por_ok;
  endsequence

  a_irq_unmasked: assert property (@(posedge clock) disable iff (!rst_b)
    |(irq_pending & ~irq_mask) |=> irq_out_low_oe) else $error("Unmasked interrupt did not pull output low.");
  a_irq_masked: assert property (@(posedge clock) disable iff (!rst_b)
    !(|(irq_pending & ~irq_mask)) |=> !irq_out_low_oe) else $error("Interrupt output low without cause.");
  a_reset_holds: assert property (@(posedge clock) disable iff (!rst_b)
    !por_ok |=> st_reg.state == pooc_pkg::POOC_RESET) else $error("Left reset while supply low.");
  a_reset_exit: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.state == pooc_pkg::POOC_RESET && por_ok |=> st_reg.state == pooc_pkg::POOC_SHUTDOWN)
    else $error("Did not enter Shutdown after supply rose.");
  a_shutdown_bias: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.state == pooc_pkg::POOC_SHUTDOWN |-> !bias_enable && !cmd_port_enable) else $error("Bias on in Shutdown.");
  a_logic_wake: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.state == pooc_pkg::POOC_SHUTDOWN && por_ok && logic_mode && !en_low_s |=> st_reg.state == pooc_pkg::POOC_CHECK)
    else $error("Logic-mode low enable did not wake.");
  a_fault_block: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.state == pooc_pkg::POOC_CHECK && por_ok && (|st_reg.erc[2:0]) |=> st_reg.state == pooc_pkg::POOC_BIAS_OFF)
    else $error("Powered up with a fault recorded.");
  a_lockout_off: assert property (@(posedge clock) disable iff (!rst_b)
    sequenced_outputs_on && lockout && por_ok |=> st_reg.state == pooc_pkg::POOC_BIAS_OFF ##1 !bias_enable)
    else $error("Lockout did not force shutdown.");
  a_standby_entry: assert property (@(posedge clock) disable iff (!rst_b)
    st_reg.state == pooc_pkg::POOC_RESOURCE_ON && cmd_stby && !mrst_hit && !logic_mode && !lockout && por_ok
    |=> s_powering_down ##0 st_reg.to_standby)
    else $error("Standby command did not start power-down.");
  // The sequence counter bounds power-down, which keeps long delay ranges out of the checks.
  a_powerdown_bounded: assert property (@(posedge clock) disable iff (!rst_b)
    s_powering_down |-> st_reg.seq_count < pooc_pkg::COUNT_W'(SEQ_CYC))
    else $error("Power-down ran past its sequence length.");
  a_standby_reach: assert property (@(posedge clock) disable iff (!rst_b)
    s_powering_down ##0 s_standby_due |=> st_reg.state == pooc_pkg::POOC_STANDBY)
    else $error("Power-down for standby did not reach Standby.");

endmodule : pooc_controller

// ==== pooc_host_model.sv ====
// Behavioural model of the host processor or on-key at the far side of the controller.
// Assumes the bench calls its tasks; every change lands 1 ns after a rising clock edge.
module pooc_host_model (
  input wire logic clock,
  output logic power_enable_in_low,
  output logic [2:0] software_control_cmd,
  output logic software_control_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // The enable pin has a pull-up, so an idle host leaves it high.
  initial begin
    power_enable_in_low = 1'b1;
    software_control_cmd = 3'h0;
    software_control_strobe = 1'b0;
  end

  // Drive the enable pin as a logic output of the supervising processor.
  task automatic set_pin(input logic v);
    @(posedge clock);
    #1;
    power_enable_in_low = v;
  endtask : set_pin

  // A key press: low for n+1 cycles, then back to the pulled-up level.
  task automatic press(input int n);
    set_pin(1'b0);
    repeat (n) @(posedge clock);
    set_pin(1'b1);
  endtask : press

  // One strobed command; outside the strobe the bus shows the inverse value.
  // That inverse of standby entry is the leave code, which must still be ignored.
  task automatic send_cmd(input logic [2:0] c);
    @(posedge clock);
    #1;
    software_control_cmd = c;
    software_control_strobe = 1'b1;
    @(posedge clock);
    #1;
    software_control_strobe = 1'b0;
    software_control_cmd = ~c;
  endtask : send_cmd
endmodule : pooc_host_model

// ==== tb_top.sv ====
// Self-checking bench for the power on/off controller.
// Assumes the host model drives enable and commands; all else is driven here.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic supply_above_por = 1'b0;
  logic [2:0] fault = 3'h0;
  logic power_enable_in_low;
  logic [1:0] enable_input_mode = 2'h2;
  logic [2:0] software_control_cmd;
  logic software_control_strobe;
  logic [7:0] irq_pending = 8'h00;
  logic [7:0] irq_mask = 8'hFF;
  logic erc_clear = 1'b0;
  logic irq_out_low_o, irq_out_low_oe, bias_enable, cmd_port_enable;
  logic sequenced_outputs_on, forced_outputs_on;
  logic [pooc_pkg::ERC_W-1:0] event_record_flags;
  logic [2:0] controller_state;
  int n_mismatch = 0;
  int tests_run = 0;

  // Short counts keep the run brief; sequence and hold waits below are derived from them, the rest are fixed counts.
  localparam int MRST = 20;
  localparam int DEB = 4;
  localparam int SEQ = 3;

  always #4 clock = ~clock;

  pooc_host_model host (.clock(clock), .power_enable_in_low(power_enable_in_low),
    .software_control_cmd(software_control_cmd), .software_control_strobe(software_control_strobe));

  pooc_controller #(.IRQ_W(8), .MRST_CYC(MRST), .DEB_CYC(DEB), .SEQ_CYC(SEQ)) dut (
    .clock(clock), .rst_b(rst_b), .supply_above_por(supply_above_por),
    .supply_uvlo(fault[0]), .supply_ovlo(fault[1]), .thermal_overload_flag(fault[2]),
    .power_enable_in_low(power_enable_in_low), .enable_input_mode(enable_input_mode),
    .software_control_cmd(software_control_cmd), .software_control_strobe(software_control_strobe),
    .irq_pending(irq_pending), .irq_mask(irq_mask), .erc_clear(erc_clear),
    .irq_out_low_o(irq_out_low_o), .irq_out_low_oe(irq_out_low_oe), .bias_enable(bias_enable),
    .cmd_port_enable(cmd_port_enable), .sequenced_outputs_on(sequenced_outputs_on),
    .forced_outputs_on(forced_outputs_on), .event_record_flags(event_record_flags),
    .controller_state(controller_state));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Polls once a cycle, so a state that stands one cycle is still caught.
  task automatic wait_state(input logic [2:0] s, input int lim, input string m);
    for (int i = 0; i < lim && controller_state !== s; i++) begin
      tick(1);
    end
    chk(controller_state === s, m);
  endtask : wait_state

  task automatic clear_flags;
    tick(1);
    erc_clear = 1'b1;
    tick(1);
    erc_clear = 1'b0;
    tick(1);
  endtask : clear_flags

  // A press long enough to debounce but shorter than the manual-reset hold.
  task automatic wake_push;
    host.press(DEB + 6);
    wait_state(3'(pooc_pkg::POOC_RESOURCE_ON), 30, "push wake did not reach resource on");
  endtask : wake_push

  task automatic flag_is(input int b, input string m);
    chk(event_record_flags[b] === 1'b1, m);
  endtask : flag_is

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    rst_b = 1'b1;
    tick(8);
    chk(controller_state === 3'(pooc_pkg::POOC_RESET), "left reset with supply low");
    supply_above_por = 1'b1;
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), 6, "no shutdown after supply rise");
    chk(bias_enable === 1'b0 && cmd_port_enable === 1'b0, "bias or port on in shutdown");
    // Interrupt pin: only unmasked pending bits pull it low.
    irq_pending = 8'h05;
    irq_mask = 8'h05;
    tick(3);
    chk(irq_out_low_oe === 1'b0, "masked interrupt drove pin");
    irq_mask = 8'hFB;
    tick(3);
    chk(irq_out_low_oe === 1'b1 && irq_out_low_o === 1'b0, "unmasked interrupt idle");
    irq_pending = 8'h00;
    tick(3);
    chk(irq_out_low_oe === 1'b0, "pin held after pending cleared");
    // Logic mode: level wake with no debounce, then level off.
    host.set_pin(1'b0);
    wait_state(3'(pooc_pkg::POOC_CHECK), 5, "logic low did not wake");
    tick(1);
    chk(controller_state === 3'(pooc_pkg::POOC_POWER_UP), "no power-up after check");
    wait_state(3'(pooc_pkg::POOC_RESOURCE_ON), SEQ + 2, "logic wake missed resource on");
    chk(sequenced_outputs_on === 1'b1 && bias_enable === 1'b1, "outputs off in resource on");
    clear_flags();
    host.set_pin(1'b1);
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), SEQ + 10, "logic high did not power down");
    flag_is(pooc_pkg::ERC_MRST, "logic off flag not set");
    // Push-button mode: standby round trip and a refused command.
    enable_input_mode = pooc_pkg::MODE_PUSH_BUTTON;
    wake_push();
    host.send_cmd(pooc_pkg::SWC_ENTER_STANDBY);
    wait_state(3'(pooc_pkg::POOC_STANDBY), SEQ + 5, "no standby");
    chk(sequenced_outputs_on === 1'b0 && forced_outputs_on === 1'b1, "standby outputs");
    chk(bias_enable === 1'b1 && cmd_port_enable === 1'b1, "bias off in standby");
    host.send_cmd(pooc_pkg::SWC_LEAVE_STANDBY);
    wait_state(3'(pooc_pkg::POOC_RESOURCE_ON), SEQ + 5, "no return from standby");
    host.send_cmd(pooc_pkg::SWC_LEAVE_STANDBY);
    tick(4);
    chk(controller_state === 3'(pooc_pkg::POOC_RESOURCE_ON), "leave code acted outside standby");
    clear_flags();
    host.send_cmd(pooc_pkg::SWC_POWER_OFF);
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), SEQ + 5, "power-off did not shut down");
    tick(10);
    flag_is(pooc_pkg::ERC_SFT_OFF, "off flag lost in shutdown");
    chk(controller_state === 3'(pooc_pkg::POOC_SHUTDOWN), "woke without a wake source");
    clear_flags();
    chk(event_record_flags === 6'h00, "flags not cleared");
    // Cold reset: power down, then restart on the internal wake flag.
    wake_push();
    host.send_cmd(pooc_pkg::SWC_COLD_RESET);
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), SEQ + 5, "cold reset did not shut down");
    wait_state(3'(pooc_pkg::POOC_RESOURCE_ON), SEQ + 10, "cold reset did not restart");
    flag_is(pooc_pkg::ERC_SFT_COLD, "cold flag not set");
    // Each lockout forces shutdown and then blocks power-up while flagged.
    for (int i = 0; i < 3; i++) begin
      fault[i] = 1'b1;
      wait_state(3'(pooc_pkg::POOC_SHUTDOWN), 8, "lockout did not shut down");
      flag_is(i, "lockout flag not set");
      host.press(DEB + 6);
      tick(15);
      chk(controller_state === 3'(pooc_pkg::POOC_SHUTDOWN), "powered up with a fault");
      chk(sequenced_outputs_on === 1'b0, "outputs on with a fault");
      fault[i] = 1'b0;
      clear_flags();
      wake_push();
    end
    // Slide switch held high in resource on is a manual reset.
    enable_input_mode = pooc_pkg::MODE_SLIDE_SWITCH;
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), MRST + SEQ + 15, "slide hold did not reset");
    flag_is(pooc_pkg::ERC_MRST, "slide reset flag not set");
    supply_above_por = 1'b0;
    wait_state(3'(pooc_pkg::POOC_RESET), 5, "supply loss did not force reset");
    supply_above_por = 1'b1;
    enable_input_mode = pooc_pkg::MODE_PUSH_BUTTON;
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), 6, "no shutdown after supply return");
    clear_flags();
    wake_push();
    // Push button held low in resource on is a manual reset.
    host.set_pin(1'b0);
    wait_state(3'(pooc_pkg::POOC_SHUTDOWN), MRST + DEB + SEQ + 15, "push hold did not reset");
    flag_is(pooc_pkg::ERC_MRST, "push reset flag not set");
    host.set_pin(1'b1);
    supply_above_por = 1'b0;
    wait_state(3'(pooc_pkg::POOC_RESET), 5, "supply loss ignored");
    tick(5);
    chk(controller_state === 3'(pooc_pkg::POOC_RESET), "left reset while supply low");
    stop_test();
  end
endmodule : tb_top
